/* File: rtl/host_clock_divider.sv */
// divides the oscillator half-period tick into the host clock output
module host_clock_divider (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_osc_half_tick,
    input wire logic [1:0] i_clk_sel,
    output logic o_clk
);
    import modclk_pkg::*;

    logic [1:0] cnt; // half ticks counted so far
    logic [1:0] next_cnt;
    logic next_clk;
    logic [1:0] limit; // last count before a toggle

    // next count and output level
    always_comb begin
        case (i_clk_sel)
            CLKSEL_DIV1: limit = HALF_TICKS_DIV1;
            CLKSEL_DIV2: limit = HALF_TICKS_DIV2;
            default: limit = HALF_TICKS_DIV4;
        endcase
        next_cnt = cnt;
        next_clk = o_clk;
        if (i_clk_sel == CLKSEL_OFF) begin
            // parked low so the host sees no runt pulse on restart
            next_cnt = 2'h0;
            next_clk = 1'b0;
        end else if (i_osc_half_tick) begin
            // >= so a select change to a faster rate never overshoots
            if (cnt >= limit) begin
                next_cnt = 2'h0;
                next_clk = ~o_clk;
            end else begin
                next_cnt = cnt + 2'h1;
            end
        end
    end

    // register count and output
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            cnt <= 2'h0;
            o_clk <= 1'b0;
        end else begin
            cnt <= next_cnt;
            o_clk <= next_clk;
        end
    end

    property p_div1_toggles;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_clk_sel == CLKSEL_DIV1 && $past(i_clk_sel) == CLKSEL_DIV1 && i_osc_half_tick)
            |=> (o_clk != $past(o_clk));
    endproperty
    a_div1_toggles: assert property (p_div1_toggles) else $error("div1 output missed a toggle");

    property p_div4_holds;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_clk_sel == CLKSEL_DIV4 && cnt == 2'h0 && i_osc_half_tick)
            |=> (o_clk == $past(o_clk));
    endproperty
    a_div4_holds: assert property (p_div4_holds) else $error("div4 output toggled too early");
endmodule

/* File: rtl/modclk_pkg.sv */
// shared constants for the modulator / host clock control block
package modclk_pkg;
    // register index as printed, byte address is four times it
    localparam int unsigned MODCLK_REG_INDEX = 9;
    localparam logic [7:0] MODCLK_REG_ADDR = 8'(MODCLK_REG_INDEX * 4);
    // read-only status word
    localparam logic [7:0] STATUS_REG_ADDR = 8'h40;
    // value taken at reset and chip disable, and outside the clock select pair on protocol-control writes
    localparam logic [7:0] MODCLK_RESET = 8'h11;
    // field positions
    localparam int unsigned EXT_SEL_BIT = 6;
    localparam int unsigned CLK_SEL_HI = 5;
    localparam int unsigned CLK_SEL_LO = 4;
    localparam int unsigned ANALOG_BIT = 3;
    localparam int unsigned DEPTH_HI = 2;
    localparam int unsigned DEPTH_LO = 0;
    // bits kept across a protocol-control write (the clock select pair)
    localparam logic [7:0] KEEP_ON_PROTO_MASK = 8'h30;
    // clock select codes
    localparam logic [1:0] CLKSEL_OFF = 2'h0;
    localparam logic [1:0] CLKSEL_DIV4 = 2'h1;
    localparam logic [1:0] CLKSEL_DIV2 = 2'h2;
    localparam logic [1:0] CLKSEL_DIV1 = 2'h3;
    // last half-tick count before a toggle, one less than the oscillator half periods per output half period
    localparam logic [1:0] HALF_TICKS_DIV1 = 2'h0;
    localparam logic [1:0] HALF_TICKS_DIV2 = 2'h1;
    localparam logic [1:0] HALF_TICKS_DIV4 = 2'h3;
    // depth code meaning full on/off keying
    localparam logic [2:0] DEPTH_OOK = 3'h1;
    // oscillator figures, for reference by users of the block
    localparam real OSC_FREQ_MHZ = 13.56;
    localparam real REF_CLK_MHZ = 100.0;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

/* File: rtl/modulator_sysclk_control.sv */
// How it works
// - reset, chip disable restore default; protocol write restores all but clock select
// - host clock is oscillator divided 1/2/4
// - clock select 00 off, 01/10/11 rising rates
// - depth field selects ASK depth or OOK
// - external bit clear: depth field alone rules
// - pin selection needs both enable bits set
// - external mode takes waveform from modulation pin
// - analog bit turns ASK/OOK pin into output
module modulator_sysclk_control (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // chip enable, low holds the register at default
    input wire logic i_chip_en,
    // pulse on each write to the protocol-control register
    input wire logic i_proto_write,
    // level of the pin-select enable bit of the protocol-control register
    input wire logic i_proto_ook_pin_en,
    // ASK/OOK pin input side and modulation pin
    input wire logic i_ask_ook_pin,
    input wire logic i_modulation_input_pin,
    // internal encoder waveform, used when the pin is not selected
    input wire logic i_encoder_modulate,
    // one pulse per oscillator half period
    input wire logic i_osc_half_tick,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // transmitter controls
    output logic [2:0] o_mod_depth,
    output logic o_mod_is_ook,
    output logic o_tx_modulate,
    output logic o_ext_select_active,
    output logic o_ask_ook_analog_en,
    output logic o_host_clock_output
);
    import modclk_pkg::*;

    logic [7:0] ctrl; // the control register
    logic [7:0] next_ctrl;

    // write channel holding state
    logic aw_held; // address taken, waiting for data
    logic w_held; // data taken, waiting for address
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic next_aw_held;
    logic next_w_held;
    logic [7:0] next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic do_write; // both halves present this cycle
    logic hit_ctrl; // the write lands in the control register

    // read channel
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;

    // transmitter outputs
    logic ext_active; // pin selection allowed by both enables
    logic [2:0] next_depth;
    logic next_is_ook;
    logic next_tx_mod;
    logic next_ext_active;
    logic next_analog;

    // accept each half only while it is not already held and no answer waits
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    // write path: capture halves in any order, answer when both are in
    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        do_write = next_aw_held && next_w_held;
        hit_ctrl = do_write && (next_aw_addr == MODCLK_REG_ADDR) && next_w_strb[0];
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            // status is read only, so a write there is refused too
            if (next_aw_addr == MODCLK_REG_ADDR) begin
                next_bresp = RESP_OKAY;
            end else begin
                next_bresp = RESP_DECERR;
            end
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
    end

    // control register next value, chip disable ahead of software, software ahead of protocol restore
    always_comb begin
        next_ctrl = ctrl;
        if (!i_chip_en) begin
            next_ctrl = MODCLK_RESET;
        end else begin
            if (i_proto_write) begin
                // clock select survives so the host clock does not glitch
                next_ctrl = (ctrl & KEEP_ON_PROTO_MASK) | (MODCLK_RESET & ~KEEP_ON_PROTO_MASK);
            end
            // a software write in the same cycle lands after the restore
            if (hit_ctrl) begin
                next_ctrl = next_w_data[7:0];
            end
        end
    end

    // read path, unmapped addresses read zero with a decode error
    always_comb begin
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            if (s_axi_araddr == MODCLK_REG_ADDR) begin
                next_rdata = {24'h0, ctrl};
            end else if (s_axi_araddr == STATUS_REG_ADDR) begin
                next_rdata = {24'h0, o_host_clock_output, o_ext_select_active,
                              o_ask_ook_analog_en, o_mod_is_ook, 1'b0, o_mod_depth};
            end else begin
                next_rdata = 32'h0;
                next_rresp = RESP_DECERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    // effective modulation, recomputed every cycle from register and pins
    always_comb begin
        ext_active = ctrl[EXT_SEL_BIT] && i_proto_ook_pin_en;
        next_ext_active = ext_active;
        next_analog = ctrl[ANALOG_BIT];
        next_depth = ctrl[DEPTH_HI:DEPTH_LO];
        // an analog pin carries no level to select with, so ASK stands
        if (ext_active && !ctrl[ANALOG_BIT] && i_ask_ook_pin) begin
            next_depth = DEPTH_OOK;
        end
        next_is_ook = (next_depth == DEPTH_OOK);
        if (ext_active) begin
            next_tx_mod = i_modulation_input_pin;
        end else begin
            next_tx_mod = i_encoder_modulate;
        end
    end

    // all state registered here except the host clock divider's count and output
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            ctrl <= MODCLK_RESET;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
            o_mod_depth <= 3'h0;
            o_mod_is_ook <= 1'b0;
            o_tx_modulate <= 1'b0;
            o_ext_select_active <= 1'b0;
            o_ask_ook_analog_en <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
            o_mod_depth <= next_depth;
            o_mod_is_ook <= next_is_ook;
            o_tx_modulate <= next_tx_mod;
            o_ext_select_active <= next_ext_active;
            o_ask_ook_analog_en <= next_analog;
        end
    end

    // host clock divider, rate from the select pair
    host_clock_divider u_host_clock_divider (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_osc_half_tick(i_osc_half_tick),
        .i_clk_sel(ctrl[CLK_SEL_HI:CLK_SEL_LO]),
        .o_clk(o_host_clock_output)
    );

    property p_disable_default;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        !i_chip_en |=> (ctrl == MODCLK_RESET);
    endproperty
    a_disable_default: assert property (p_disable_default) else $error("ctrl not default");

    property p_proto_restore;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_chip_en && i_proto_write && !hit_ctrl) |=>
            ((ctrl & KEEP_ON_PROTO_MASK) == ($past(ctrl) & KEEP_ON_PROTO_MASK))
            && ((ctrl & ~KEEP_ON_PROTO_MASK) == (MODCLK_RESET & ~KEEP_ON_PROTO_MASK));
    endproperty
    a_proto_restore: assert property (p_proto_restore) else $error("bad protocol restore");

    property p_clock_off;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (ctrl[5:4] == CLKSEL_OFF)[*2] |-> !o_host_clock_output;
    endproperty
    a_clock_off: assert property (p_clock_off) else $error("host clock not stopped");

    property p_depth_follows;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        // the release edge still runs the reset branch, so it is left out
        (!i_sys_rst && !ctrl[EXT_SEL_BIT]) |=> (o_mod_depth == $past(ctrl[2:0]))
            && (o_mod_is_ook == ($past(ctrl[2:0]) == DEPTH_OOK));
    endproperty
    a_depth_follows: assert property (p_depth_follows) else $error("depth mismatch");

    property p_ext_needs_both;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (!ctrl[EXT_SEL_BIT] || !i_proto_ook_pin_en) |=> !o_ext_select_active;
    endproperty
    a_ext_needs_both: assert property (p_ext_needs_both) else $error("ext select leaked");

    property p_ext_waveform;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        ext_active |=> (o_tx_modulate == $past(i_modulation_input_pin));
    endproperty
    a_ext_waveform: assert property (p_ext_waveform) else $error("waveform not from pin");

    property p_analog_pin;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        $changed(ctrl[ANALOG_BIT]) |=> (o_ask_ook_analog_en == $past(ctrl[ANALOG_BIT]));
    endproperty
    a_analog_pin: assert property (p_analog_pin) else $error("analog enable lag");

    property p_pin_ook;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (ext_active && !ctrl[ANALOG_BIT] && i_ask_ook_pin) |=> o_mod_is_ook;
    endproperty
    a_pin_ook: assert property (p_pin_ook) else $error("pin high did not give OOK");

    property p_bvalid_holds;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid;
    endproperty
    a_bvalid_holds: assert property (p_bvalid_holds) else $error("bvalid dropped early");
endmodule

/* File: sim/host_pin_model.sv */
// host side of the transmitter pins: waveform and ask/ook select
module host_pin_model (
    input wire logic i_ref_clk,
    input wire logic i_ook_level,
    output logic o_ask_ook_pin,
    output logic o_mod_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    // paces the waveform, slower than the bench clock on purpose
    logic [1:0] pace;
    initial begin
        pace = 2'h0;
        o_mod_pin = 1'b0;
        o_ask_ook_pin = 1'b0;
    end
    // host keeps the modulation waveform running, uneven to the tick
    always @(posedge i_ref_clk) begin
        pace <= (pace == 2'h2) ? 2'h0 : pace + 2'h1;
        if (pace == 2'h2) begin
            o_mod_pin <= ~o_mod_pin;
        end
        o_ask_ook_pin <= i_ook_level;
    end
endmodule

/* File: sim/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import modclk_pkg::*;
    logic clk, rst, chip_en, proto_wr, proto_en, ook_level, enc, tick;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [2:0] depth;
    logic is_ook, tx, ext, ana, hclk, ask_pin, mod_pin;
    int miscompares, total_checks, cyc;
    modulator_sysclk_control i_modulator_sysclk_control (
        .i_ref_clk(clk), .i_sys_rst(rst), .i_chip_en(chip_en),
        .i_proto_write(proto_wr), .i_proto_ook_pin_en(proto_en),
        .i_ask_ook_pin(ask_pin), .i_modulation_input_pin(mod_pin),
        .i_encoder_modulate(enc), .i_osc_half_tick(tick),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .o_mod_depth(depth),
        .o_mod_is_ook(is_ook), .o_tx_modulate(tx), .o_ext_select_active(ext),
        .o_ask_ook_analog_en(ana), .o_host_clock_output(hclk)
    );
    host_pin_model i_host_pin_model (
        .i_ref_clk(clk), .i_ook_level(ook_level),
        .o_ask_ook_pin(ask_pin), .o_mod_pin(mod_pin)
    );
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // oscillator half tick every second cycle, encoder waveform every cycle
    always @(posedge clk) begin
        tick <= ~tick;
        enc <= ~enc;
    end
    task automatic print_verdict;
        if (miscompares == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // watchdog against a hung handshake
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            print_verdict;
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // decisions sampled at negedge, where inputs are settled for the next edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
        logic ta, tw, tb, tv;
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (int n = 0; n < 100; n++) begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid && bready;
            tv = bvalid;
            r = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) begin
                bready <= 1'b0;
                break;
            end
            // ready raised only once the answer shows, so the answer is seen waiting
            if (tv) bready <= 1'b1;
        end
        chk("bresp_wait", 32'h1, 32'(tb));
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 100; n++) begin
            @(negedge clk);
            ta = arvalid && arready;
            tr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
            if (tr) begin
                rready <= 1'b0;
                break;
            end
        end
        chk("rvalid_wait", 32'h1, 32'(tr));
        @(posedge clk);
    endtask
    // write control word and let the outputs settle
    task automatic setc(input logic [7:0] d);
        logic [1:0] r;
        wr(MODCLK_REG_ADDR, d, r);
        repeat (4) @(posedge clk);
    endtask
    task automatic t_depth;
        logic p;
        proto_en <= 1'b1; // pin enable alone must not take over
        for (int i = 0; i < 8; i++) begin
            setc(8'(i));
            @(negedge clk);
            p = enc;
            @(negedge clk);
            chk("depth", 32'(i), 32'(depth));
            chk("is_ook", 32'(i == 1), 32'(is_ook));
            chk("ext", 32'h0, 32'(ext));
            chk("tx_enc", 32'(p), 32'(tx));
            @(posedge clk);
        end
    endtask
    task automatic t_clock;
        int cnt, e;
        logic prev;
        for (int s = 0; s < 4; s++) begin
            setc({2'h0, 2'(s), 4'h0});
            e = (s == 0) ? 0 : (8 << (s - 1));
            cnt = 0;
            @(negedge clk);
            prev = hclk;
            for (int n = 0; n < 128; n++) begin
                @(negedge clk);
                if (hclk && !prev) cnt++;
                prev = hclk;
            end
            // phase at start may add or lose one edge
            if (cnt >= e - 1 && cnt <= e + 1) cnt = e;
            chk("clk_rises", 32'(e), 32'(cnt));
            @(posedge clk);
        end
    endtask
    task automatic t_ext;
        logic p;
        proto_en <= 1'b0;
        ook_level <= 1'b1;
        setc(8'h45);
        @(negedge clk);
        chk("ext_off", 32'h0, 32'(ext));
        chk("depth_off", 32'h5, 32'(depth));
        @(posedge clk);
        proto_en <= 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        p = mod_pin;
        // several cycles, so the pin waveform cannot match the encoder by luck
        for (int k = 0; k < 3; k++) begin
            @(negedge clk);
            chk("tx_pin", 32'(p), 32'(tx));
            p = mod_pin;
        end
        chk("ext_on", 32'h1, 32'(ext));
        chk("ook_pin_hi", 32'h1, 32'(is_ook));
        chk("depth_pin_hi", 32'(DEPTH_OOK), 32'(depth));
        @(posedge clk);
        ook_level <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk("ook_pin_lo", 32'h0, 32'(is_ook));
        chk("depth_pin_lo", 32'h5, 32'(depth));
        @(posedge clk);
    endtask
    task automatic t_analog;
        logic [31:0] d;
        logic [1:0] r;
        setc(8'h08);
        @(negedge clk);
        chk("analog_on", 32'h1, 32'(ana));
        @(posedge clk);
        // status: analog set, clock off, depth 0, no pin selection
        rd(STATUS_REG_ADDR, d, r);
        chk("status_word", 32'h20, d);
        setc(8'h00);
        @(negedge clk);
        chk("analog_off", 32'h0, 32'(ana));
        @(posedge clk);
    endtask
    task automatic t_restore;
        logic [31:0] d;
        logic [1:0] r;
        setc(8'h7e);
        proto_wr <= 1'b1;
        @(posedge clk);
        proto_wr <= 1'b0;
        repeat (2) @(posedge clk);
        rd(MODCLK_REG_ADDR, d, r);
        chk("proto_keep", 32'h31, d);
        chk("proto_okay", 32'(RESP_OKAY), 32'(r));
        chip_en <= 1'b0;
        @(posedge clk);
        chip_en <= 1'b1;
        @(posedge clk);
        rd(MODCLK_REG_ADDR, d, r);
        chk("chip_dis", 32'(MODCLK_RESET), d);
    endtask
    task automatic t_bus_err;
        logic [31:0] d;
        logic [1:0] r;
        wr(STATUS_REG_ADDR, 8'hff, r);
        chk("ro_wr_resp", 32'(RESP_DECERR), 32'(r));
        rd(8'h00, d, r);
        chk("unmap_resp", 32'(RESP_DECERR), 32'(r));
        chk("unmap_data", 32'h0, d);
    endtask
    initial begin
        {rst, chip_en} = 2'b11;
        {proto_wr, proto_en, ook_level, enc, tick} = 5'h0;
        {awaddr, araddr, wdata, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        miscompares = 0;
        total_checks = 0;
        cyc = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_restore;
        t_depth;
        t_clock;
        t_ext;
        t_analog;
        t_bus_err;
        print_verdict;
    end
endmodule
